// ---- hdl/line_ov_output_ovp_protection.sv ----
`timescale 1ns/100ps
module line_ov_output_ovp_protection
  import ovp_seq_pkg::*;
(
  // Clock and reset.
  input  wire logic REF_CLK,
  input  wire logic SRST,
  // Sense pin comparator indications.
  input  wire logic LINE_OVERVOLTAGE,
  input  wire logic LATCH_CURRENT_HIGH,
  input  wire logic SENSE_BELOW_1V,
  input  wire logic LINE_UNDERVOLTAGE_HIGH_OK,
  // Configuration straps.
  input  wire logic OV_DISABLE,
  input  wire logic UV_DISABLE,
  // Switching cycle status.
  input  wire logic CYCLE_REQUEST,
  input  wire logic CYCLE_ACTIVE,
  // Outputs.
  output logic      SWITCH_ENABLE,
  output logic      SWITCH_FORCE_OFF,
  output logic      SENSE_STEP_DOWN,
  output logic      LATCHED_OFF,
  output logic      UV_COMPARE_ENABLE,
  output logic      RESTART_ACTIVE
);
  import ovp_seq_pkg::*;

  logic [1:0]    ov_sync_reg, cur_sync_reg, low_sync_reg, uv_sync_reg;
  logic          ov_level, cur_level, low_level, uv_level;
  logic          ov_active;
  seq_state_type state_reg, state_next;
  logic [3:0]    step_reg;
  logic          latch_reg;
  logic          force_reg;
  logic          uv_block_reg;
  logic          step_down_reg;
  logic          uv_en_reg;
  logic          enable_reg;
  persist_if     ov_pf ();
  persist_if     cur_pf ();

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ov_sync_reg  <= 2'h0;
      cur_sync_reg <= 2'h0;
      low_sync_reg <= 2'h0;
      uv_sync_reg  <= 2'h0;
    end else begin
      ov_sync_reg  <= {ov_sync_reg[0], LINE_OVERVOLTAGE};
      cur_sync_reg <= {cur_sync_reg[0], LATCH_CURRENT_HIGH};
      low_sync_reg <= {low_sync_reg[0], SENSE_BELOW_1V};
      uv_sync_reg  <= {uv_sync_reg[0], LINE_UNDERVOLTAGE_HIGH_OK};
    end
  end
  assign ov_level  = ov_sync_reg[1];
  assign cur_level = cur_sync_reg[1];
  assign low_level = low_sync_reg[1];
  assign uv_level  = uv_sync_reg[1] || UV_DISABLE;
  assign ov_active = ov_level && !OV_DISABLE;

  assign ov_pf.level  = ov_active;
  assign cur_pf.level = ov_active && cur_level;
  persist_filter ov_filter (.clk(REF_CLK), .rst(SRST), .pf(ov_pf));
  persist_filter cur_filter (.clk(REF_CLK), .rst(SRST), .pf(cur_pf));

  always_ff @(posedge REF_CLK) begin
    if (SRST || low_level) begin
      latch_reg <= 1'b0;
    end else if (cur_pf.done) begin
      latch_reg <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      step_down_reg <= 1'b0;
    end else begin
      step_down_reg <= ov_active;
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RUN_ST: begin
        if (ov_active) begin
          state_next = HALT_ST;
        end
      end
      HALT_ST: begin
        if (!ov_active) begin
          state_next = ENTRY_ST;
        end
      end
      ENTRY_ST: begin
        state_next = RESTART_ST;
      end
      RESTART_ST: begin
        if (ov_active) begin
          state_next = HALT_ST;
        end else if (step_reg == 4'(RESTART_CYCLES - 1)) begin
          state_next = FINAL_ST;
        end
      end
      FINAL_ST: begin
        if (ov_active) begin
          state_next = HALT_ST;
        end else if (uv_level) begin
          state_next = RUN_ST;
        end else begin
          state_next = ENTRY_ST;
        end
      end
      default: begin
        state_next = RUN_ST;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_reg <= ENTRY_ST;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST || state_reg != RESTART_ST) begin
      step_reg <= STEP_RESET;
    end else begin
      step_reg <= step_reg + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST || state_reg == ENTRY_ST) begin
      force_reg <= 1'b0;
    end else if (ov_pf.done) begin
      force_reg <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      uv_en_reg    <= 1'b0;
      uv_block_reg <= 1'b0;
    end else begin
      uv_en_reg <= (state_reg == FINAL_ST);
      if (state_reg == FINAL_ST) begin
        uv_block_reg <= !uv_level;
      end else if (state_reg == RUN_ST) begin
        uv_block_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      enable_reg <= 1'b0;
    end else begin
      enable_reg <= (state_reg == RUN_ST) && !ov_active && !latch_reg && !force_reg
                    && CYCLE_REQUEST;
    end
  end

  assign SWITCH_ENABLE     = enable_reg && !latch_reg;
  assign SWITCH_FORCE_OFF  = force_reg || latch_reg || uv_block_reg;
  assign SENSE_STEP_DOWN   = step_down_reg;
  assign LATCHED_OFF       = latch_reg;
  assign UV_COMPARE_ENABLE = uv_en_reg;
  assign RESTART_ACTIVE    = (state_reg != RUN_ST);

  no_new_cycle_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    ov_active |=> !enable_reg)
    else $error("Switching started during line overvoltage.");
  force_off_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    ov_pf.done |=> SWITCH_FORCE_OFF)
    else $error("Switch not forced off after persistence.");
  restart_entry_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_reg == HALT_ST) && !ov_active |=> state_reg == ENTRY_ST)
    else $error("Restart entry not taken after overvoltage cleared.");
  ov_disable_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    OV_DISABLE |=> !SENSE_STEP_DOWN)
    else $error("Overvoltage active while disabled.");
  step_down_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    $rose(ov_active) |=> SENSE_STEP_DOWN)
    else $error("Sense step-down missing.");
  latch_set_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    cur_pf.done && !low_level |=> LATCHED_OFF ##1 (LATCHED_OFF || $past(low_level)))
    else $error("Latch did not set.");
  latch_clear_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    low_level |=> !LATCHED_OFF)
    else $error("Latch did not clear on low sense pin.");
  latch_hold_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    LATCHED_OFF && !low_level |=> LATCHED_OFF)
    else $error("Latch cleared without cause.");
  short_path_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    !cur_pf.done && !LATCHED_OFF |=> !LATCHED_OFF || $past(low_level))
    else $error("Latch set without full persistence.");
  uv_final_a: assert property (@(posedge REF_CLK) disable iff (SRST)
    (state_reg == FINAL_ST) && !uv_level && !ov_active |=> state_reg == ENTRY_ST
      && UV_COMPARE_ENABLE)
    else $error("Undervoltage check at final state wrong.");
endmodule

// ---- hdl/persist_filter.sv ----
`timescale 1ns/100ps
module persist_filter
  import ovp_seq_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Qualified indication and result.
  persist_if.filt  pf
);
  import ovp_seq_pkg::*;

  logic [CNT_W-1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst || !pf.level) begin
      cnt_reg <= CNT_RESET;
    end else if (cnt_reg != CNT_W'(PERSIST_CYCLES)) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign pf.done = pf.level && (cnt_reg == CNT_W'(PERSIST_CYCLES));

  count_restart_a: assert property (@(posedge clk) disable iff (rst)
    !pf.level |=> cnt_reg == CNT_RESET)
    else $error("Filter count did not restart.");
endmodule

// ---- include/ovp_seq_pkg.sv ----
// How it works
// - While the line overvoltage indication is high no new switching cycle starts, and the switch enable drops on the third clock, after the two-stage synchroniser.
// - A line overvoltage indication held for at least 100 us forces the switch output off.
// - When the line overvoltage indication clears, the sequencer enters the restart entry state and runs the whole restart sequence before switching again.
// - The line overvoltage function can be disabled without touching the line undervoltage function.
// - A line overvoltage trip starts the output overvoltage check, steps the sense pin down by 0.5 V and evaluates the sense current at once.
// - A sense current above the latch threshold for longer than 100 us latches the switch output permanently off.
// - The permanent-off latch clears only when the sense pin falls below 1 V or the control supply drops below its reset threshold.
// - A sense current that never passes the latch threshold, or passes it for no more than 100 us, takes the ordinary line overvoltage path.
// - At the end of each restart cycle the undervoltage comparator is enabled, and without the high undervoltage threshold the switch stays off for the next cycle.
package ovp_seq_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned PERSIST_TIME_NS  = 100000;
  localparam int unsigned PERSIST_CYCLES   = (PERSIST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W            = 16;
  localparam logic [CNT_W-1:0] CNT_RESET   = 16'h0000;
  localparam int unsigned RESTART_CYCLES   = 8;
  localparam logic [3:0] STEP_RESET        = 4'h0;

  typedef enum logic [4:0] {
    RUN_ST     = 5'b00001,
    HALT_ST    = 5'b00010,
    ENTRY_ST   = 5'b00100,
    RESTART_ST = 5'b01000,
    FINAL_ST   = 5'b10000
  } seq_state_type;
endpackage

// ---- include/persist_if.sv ----
`timescale 1ns/100ps
interface persist_if;
  logic level;
  logic done;
  modport filt (input level, output done);
  modport user (output level, input done);
endinterface

// ---- testbench/line_ov_output_ovp_protection_bench.sv ----
`timescale 1ns/100ps
module line_ov_output_ovp_protection_bench;
  import ovp_seq_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic line_high = 1'b0;
  logic bias_surge = 1'b0;
  logic sense_short = 1'b0;
  logic line_ok = 1'b1;
  logic ov_dis = 1'b0;
  logic uv_dis = 1'b0;
  logic cyc_req = 1'b1;
  logic ov, amps, low, uv_ok, en, off, step, latched, uv_cmp, rst_act;
  int   fails = 0;
  int   total_checks = 0;
  int   cycles = 0;

  initial forever #2.5 ref_clk = ~ref_clk;

  sense_network_model net (.line_high(line_high), .bias_surge(bias_surge),
    .sense_short(sense_short), .line_ok(line_ok), .step_down(step),
    .ov_ind(ov), .amps_ind(amps), .low_ind(low), .uv_ok_ind(uv_ok));

  line_ov_output_ovp_protection dut (.REF_CLK(ref_clk), .SRST(srst),
    .LINE_OVERVOLTAGE(ov), .LATCH_CURRENT_HIGH(amps), .SENSE_BELOW_1V(low),
    .LINE_UNDERVOLTAGE_HIGH_OK(uv_ok), .OV_DISABLE(ov_dis), .UV_DISABLE(uv_dis),
    .CYCLE_REQUEST(cyc_req), .CYCLE_ACTIVE(1'b0), .SWITCH_ENABLE(en),
    .SWITCH_FORCE_OFF(off), .SENSE_STEP_DOWN(step), .LATCHED_OFF(latched),
    .UV_COMPARE_ENABLE(uv_cmp), .RESTART_ACTIVE(rst_act));

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic restart_ok();
    logic seen;
    seen = 1'b0;
    repeat (20) begin
      tick(1);
      seen |= uv_cmp;
    end
    chk("uv compare pulse", 1'b1, seen);
    chk("restart active", 1'b0, rst_act);
    chk("switch enable", 1'b1, en);
  endtask

  task automatic t_reset();
    tick(2);
    chk("restart in reset", 1'b1, rst_act);
    chk("latch in reset", 1'b0, latched);
    @(posedge ref_clk) srst <= 1'b0;
    restart_ok();
  endtask

  task automatic t_short_ov();
    @(posedge ref_clk) line_high <= 1'b1;
    tick(4);
    chk("enable on ov", 1'b0, en);
    chk("step down", 1'b1, step);
    chk("early force off", 1'b0, off);
    @(posedge ref_clk) line_high <= 1'b0;
    tick(4);
    chk("restart entry", 1'b1, rst_act);
    chk("enable in restart", 1'b0, en);
    restart_ok();
    @(posedge ref_clk) cyc_req <= 1'b0;
    tick(2);
    chk("enable without request", 1'b0, en);
    @(posedge ref_clk) cyc_req <= 1'b1;
    tick(2);
    chk("enable with request", 1'b1, en);
  endtask

  task automatic t_persist();
    @(posedge ref_clk) line_high <= 1'b1;
    tick(15000);
    @(posedge ref_clk) line_high <= 1'b0;
    restart_ok();
    @(posedge ref_clk) line_high <= 1'b1;
    tick(1000);
    @(posedge ref_clk) bias_surge <= 1'b1;
    tick(100);
    @(posedge ref_clk) bias_surge <= 1'b0;
    tick(18885);
    chk("force off before count", 1'b0, off);
    tick(20);
    chk("force off after count", 1'b1, off);
    chk("no latch on short surge", 1'b0, latched);
    @(posedge ref_clk) line_high <= 1'b0;
    restart_ok();
  endtask

  task automatic t_latch();
    @(posedge ref_clk) line_high <= 1'b1;
    bias_surge <= 1'b1;
    tick(20030);
    chk("latched", 1'b1, latched);
    chk("force off latched", 1'b1, off);
    @(posedge ref_clk) line_high <= 1'b0;
    bias_surge <= 1'b0;
    tick(40);
    chk("latch holds", 1'b1, latched);
    chk("enable latched", 1'b0, en);
    @(posedge ref_clk) sense_short <= 1'b1;
    tick(5);
    chk("latch cleared", 1'b0, latched);
    @(posedge ref_clk) sense_short <= 1'b0;
    tick(40);
    chk("enable resumes", 1'b1, en);
  endtask

  task automatic t_disable();
    @(posedge ref_clk) ov_dis <= 1'b1;
    line_high <= 1'b1;
    tick(30);
    chk("enable ov disabled", 1'b1, en);
    @(posedge ref_clk) line_ok <= 1'b0;
    srst <= 1'b1;
    @(posedge ref_clk) srst <= 1'b0;
    tick(40);
    chk("uv block", 1'b1, off);
    chk("uv block enable", 1'b0, en);
    @(posedge ref_clk) uv_dis <= 1'b1;
    tick(40);
    chk("uv disabled", 1'b1, en);
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 90000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    t_reset();
    t_short_ov();
    t_persist();
    t_latch();
    t_disable();
    report_and_stop();
  end
endmodule

// ---- testbench/sense_network_model.sv ----
`timescale 1ns/100ps
module sense_network_model (
  // Commanded line and bias conditions.
  input  wire logic line_high,
  input  wire logic bias_surge,
  input  wire logic sense_short,
  input  wire logic line_ok,
  // Pin step from the device.
  input  wire logic step_down,
  // Comparator indications.
  output logic      ov_ind,
  output logic      amps_ind,
  output logic      low_ind,
  output logic      uv_ok_ind
);
  // The network current is only seen once the pin has stepped down.
  assign amps_ind  = bias_surge & step_down;
  assign ov_ind    = line_high & ~sense_short;
  assign low_ind   = sense_short;
  assign uv_ok_ind = line_ok & ~sense_short;
endmodule
